// [core/seq_pkg.sv]
package seq_pkg;

    // ------------------------------------------------------------------
    // Clock rate and documented times
    // ------------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 125;
    localparam int INIT_TIME_MS = 2;            // Supplies-up settle time, in ms
    localparam int INIT_CYCLES = INIT_TIME_MS * 1000 * SYS_CLK_MHZ;
    localparam int RAMP_TIME_MS = 10;           // Power-down budget, longest
    localparam int RAMP_CYCLES = RAMP_TIME_MS * 1000 * SYS_CLK_MHZ;
    localparam int SHUTDOWN_TIME_MS = 100;      // Clock-stop shutdown budget, longest
    localparam int SHUTDOWN_CYCLES = SHUTDOWN_TIME_MS * 1000 * SYS_CLK_MHZ;
    localparam int BCLK_TIMEOUT_NS = 2000;      // No bit-clock edge for this long: gone
    localparam int BCLK_TIMEOUT_CYCLES = (BCLK_TIMEOUT_NS * SYS_CLK_MHZ) / 1000;
    localparam int FRAME_TIMEOUT_US = 250;      // Covers the slowest frame rate
    localparam int FRAME_TIMEOUT_CYCLES = FRAME_TIMEOUT_US * SYS_CLK_MHZ;

    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int CNT_W = 24;
    localparam int CFG_W = 6;
    localparam int CHAN_W = 2;
    localparam int GAIN_W = 8;
    localparam int GAIN_STEPS = 256;
    localparam logic [GAIN_W-1:0] GAIN_FULL = 8'hFF;
    localparam logic [GAIN_W-1:0] GAIN_ZERO = 8'h00;
    localparam logic [CHAN_W-1:0] CHAN_ALL = 2'h3;
    localparam logic [CHAN_W-1:0] CHAN_NONE = 2'h0;
    localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
    localparam int SYNC_W = 10;
    localparam int SYNC_FMT = 0;
    localparam int SYNC_CFG_LO = 1;
    localparam int SYNC_PFAIL = 7;
    localparam int SYNC_BCLK = 8;
    localparam int SYNC_FRAME = 9;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_INIT = 6'h01,
        ST_SLEEP = 6'h02,
        ST_ACTIVE = 6'h04,
        ST_SHUTDOWN = 6'h08,
        ST_RAMP = 6'h10,
        ST_OFF = 6'h20
    } seq_state_t;

endpackage

// [core/link_event_if.sv]
`timescale 1ns/1ps
// Toggles made in the serial bit-clock domain, read by the system domain
interface link_event_if;
    logic bclk_tgl;
    logic frame_tgl;
    modport link (output bclk_tgl, output frame_tgl);
    modport sys (input bclk_tgl, input frame_tgl);
endinterface

// [core/bit_sync.sv]
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // Destination clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] d, // Foreign-domain levels
    output logic [WIDTH-1:0] q // Synchronised levels
);
    // ------------------------------------------------------------------
    // Two flops per bit; the first is read only by the second
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic q_reg;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg <= 1'b0;
                    q_reg <= 1'b0;
                end else begin
                    meta_reg <= d[i];
                    q_reg <= meta_reg;
                end
            end
            assign q[i] = q_reg; // One driver per bit, each from its own flop
        end
    endgenerate
endmodule

// [core/link_clock_monitor.sv]
`timescale 1ns/1ps
module link_clock_monitor (
    input wire logic bclk, // Serial bit clock from the host
    input wire logic rst_n, // Supply reset, active low
    input wire logic fsync, // Frame sync, launched on bit clock
    link_event_if.link lnk // Activity toggles toward the system domain
);
    logic [1:0] rst_pipe_reg;
    logic link_rst_n;
    logic bclk_tgl_reg;
    logic frame_tgl_reg;
    logic fsync_last_reg;

    // ------------------------------------------------------------------
    // Reset: asserts at once, releases on bit-clock edges
    // ------------------------------------------------------------------
    always_ff @(posedge bclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign link_rst_n = rst_pipe_reg[1];

    // Toggles, not pulses, so a stopped clock leaves a stable level behind
    always_ff @(posedge bclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bclk_tgl_reg <= 1'b0;
            frame_tgl_reg <= 1'b0;
            fsync_last_reg <= 1'b0;
        end else begin
            bclk_tgl_reg <= ~bclk_tgl_reg;
            fsync_last_reg <= fsync;
            if (fsync && !fsync_last_reg) begin
                frame_tgl_reg <= ~frame_tgl_reg;
            end
        end
    end

    assign lnk.bclk_tgl = bclk_tgl_reg;
    assign lnk.frame_tgl = frame_tgl_reg;
endmodule

// [core/strap_pin_wake_sequencer.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Interface-format strap is captured once at power-up; only a power cycle changes it.
// - After initialisation, with no serial clocks, the device stays asleep.
// - Bit clock plus frame sync wake the device out of sleep.
// - Clocks stopping runs shutdown back to sleep; host waits 100ms before strap changes.
// - Supply power-down ramps gain to zero, disables everything, enters low power in 10ms.
// - Active with clocks: all channels powered and transmitting; clocks stop: powered down.
// - Clock stop or clock error latches the interrupt pin until a power cycle.
module strap_pin_wake_sequencer #(
    parameter int INIT_CYCLES = seq_pkg::INIT_CYCLES,
    parameter int SHUTDOWN_CYCLES = seq_pkg::SHUTDOWN_CYCLES,
    parameter int RAMP_CYCLES = seq_pkg::RAMP_CYCLES,
    parameter int FRAME_TIMEOUT_CYCLES = seq_pkg::FRAME_TIMEOUT_CYCLES
) (
    input wire logic CLK_SYS, // Internal free-running clock, 125 MHz
    input wire logic RESETN, // Supply power-up reset, active low
    input wire logic BCLK, // Serial bit clock from host
    input wire logic FSYNC, // Serial frame sync from host
    input wire logic INTERFACE_FORMAT_STRAP, // Serial format strap pin
    input wire logic [seq_pkg::CFG_W-1:0] CONFIG_STRAP, // Config straps 1 to 6
    input wire logic SUPPLY_DOWN, // Supply power-down event, high = going down
    output logic GENERAL_PURPOSE_OUTPUT_PIN, // Latched clock interrupt
    output logic SLEEP_STATE, // High while asleep
    output logic [seq_pkg::CHAN_W-1:0] CHANNEL_POWER, // Converter channel enables
    output logic TRANSMIT_ENABLE, // Serial data output enabled
    output logic FORMAT_SEL, // Captured serial format
    output logic [seq_pkg::CFG_W-1:0] CONFIG_SEL, // Config straps taken at wake
    output logic [seq_pkg::GAIN_W-1:0] RECORD_GAIN, // Record-path gain
    output logic LOW_POWER, // Final low-power state reached
    output logic INIT_DONE // Initialisation finished
);
    localparam int RAMP_STEP_CYCLES = RAMP_CYCLES / seq_pkg::GAIN_STEPS;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    link_event_if link_bus ();
    logic [seq_pkg::SYNC_W-1:0] sync_in;
    logic [seq_pkg::SYNC_W-1:0] sync_q;
    logic fmt_s;
    logic [seq_pkg::CFG_W-1:0] cfg_s;
    logic pfail_s;
    logic bclk_last_reg;
    logic frame_last_reg;
    logic bclk_evt;
    logic frame_evt;
    logic [seq_pkg::CNT_W-1:0] bclk_idle_reg;
    logic [seq_pkg::CNT_W-1:0] frame_idle_reg;
    logic bclk_alive_reg;
    logic frame_alive_reg;
    logic clocks_present;
    logic clock_lost;
    seq_pkg::seq_state_t state_reg;
    seq_pkg::seq_state_t state_next;
    logic [seq_pkg::CNT_W-1:0] seq_cnt_reg;
    logic init_end;
    logic shut_end;
    logic ramp_step;
    logic [seq_pkg::GAIN_W-1:0] gain_reg;
    logic gpo_reg;
    logic sleep_reg;
    logic [seq_pkg::CHAN_W-1:0] chan_reg;
    logic tx_reg;
    logic fmt_reg;
    logic [seq_pkg::CFG_W-1:0] cfg_reg;
    logic low_power_reg;
    logic init_done_reg;

    // ------------------------------------------------------------------
    // Link domain and crossings
    // ------------------------------------------------------------------
    link_clock_monitor u_monitor (
        .bclk(BCLK),
        .rst_n(RESETN),
        .fsync(FSYNC),
        .lnk(link_bus)
    );

    // Strap and supply-down pins and link toggles all pass two flops before any logic
    assign sync_in = {link_bus.frame_tgl, link_bus.bclk_tgl, SUPPLY_DOWN,
                      CONFIG_STRAP, INTERFACE_FORMAT_STRAP};

    bit_sync #(.WIDTH(seq_pkg::SYNC_W)) u_sync (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .d(sync_in),
        .q(sync_q)
    );

    assign fmt_s = sync_q[seq_pkg::SYNC_FMT];
    assign cfg_s = sync_q[seq_pkg::SYNC_CFG_LO +: seq_pkg::CFG_W];
    assign pfail_s = sync_q[seq_pkg::SYNC_PFAIL];

    // ------------------------------------------------------------------
    // Clock presence detection
    // ------------------------------------------------------------------
    // Any change of a synchronised toggle marks activity in the link domain
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            bclk_last_reg <= 1'b0;
            frame_last_reg <= 1'b0;
        end else begin
            bclk_last_reg <= sync_q[seq_pkg::SYNC_BCLK];
            frame_last_reg <= sync_q[seq_pkg::SYNC_FRAME];
        end
    end
    assign bclk_evt = sync_q[seq_pkg::SYNC_BCLK] ^ bclk_last_reg;
    assign frame_evt = sync_q[seq_pkg::SYNC_FRAME] ^ frame_last_reg;

    // Timeouts run on our own clock, since the serial clocks may simply stop
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            bclk_idle_reg <= '0;
            bclk_alive_reg <= 1'b0;
        end else if (bclk_evt) begin
            bclk_idle_reg <= '0;
            bclk_alive_reg <= 1'b1;
        end else if (bclk_idle_reg == seq_pkg::CNT_W'(seq_pkg::BCLK_TIMEOUT_CYCLES - 1)) begin
            bclk_alive_reg <= 1'b0;
        end else begin
            bclk_idle_reg <= bclk_idle_reg + 1'b1;
        end
    end

    // Frame timeout must exceed the slowest frame period
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            frame_idle_reg <= '0;
            frame_alive_reg <= 1'b0;
        end else if (frame_evt) begin
            frame_idle_reg <= '0;
            frame_alive_reg <= 1'b1;
        end else if (frame_idle_reg == seq_pkg::CNT_W'(FRAME_TIMEOUT_CYCLES - 1)) begin
            frame_alive_reg <= 1'b0;
        end else begin
            frame_idle_reg <= frame_idle_reg + 1'b1;
        end
    end

    // Both clocks are needed; bit clock without frames counts as an error
    assign clocks_present = bclk_alive_reg && frame_alive_reg;
    assign clock_lost = (state_reg == seq_pkg::ST_ACTIVE) && !clocks_present;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    assign init_end = seq_cnt_reg == seq_pkg::CNT_W'(INIT_CYCLES - 1);
    assign shut_end = seq_cnt_reg == seq_pkg::CNT_W'(SHUTDOWN_CYCLES - 1);
    assign ramp_step = (state_reg == seq_pkg::ST_RAMP)
                       && seq_cnt_reg == seq_pkg::CNT_W'(RAMP_STEP_CYCLES - 1);

    // Supply power-down overrides every state that is still running
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            seq_pkg::ST_INIT: begin
                if (init_end) begin
                    state_next = seq_pkg::ST_SLEEP;
                end
            end
            seq_pkg::ST_SLEEP: begin
                if (clocks_present) begin
                    state_next = seq_pkg::ST_ACTIVE;
                end
            end
            seq_pkg::ST_ACTIVE: begin
                if (!clocks_present) begin
                    state_next = seq_pkg::ST_SHUTDOWN;
                end
            end
            seq_pkg::ST_SHUTDOWN: begin
                if (shut_end) begin
                    state_next = seq_pkg::ST_SLEEP;
                end
            end
            seq_pkg::ST_RAMP: begin
                if (ramp_step && gain_reg == seq_pkg::GAIN_ZERO) begin
                    state_next = seq_pkg::ST_OFF;
                end
            end
            seq_pkg::ST_OFF: begin
                state_next = seq_pkg::ST_OFF;
            end
        endcase
        if (pfail_s && state_reg != seq_pkg::ST_RAMP && state_reg != seq_pkg::ST_OFF) begin
            state_next = seq_pkg::ST_RAMP;
        end
    end

    // Supply reset is the only reset; it starts initialisation
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= seq_pkg::ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // One timer serves init, shutdown and each ramp step
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            seq_cnt_reg <= '0;
        end else if (state_next != state_reg || ramp_step) begin
            seq_cnt_reg <= '0;
        end else if (state_reg != seq_pkg::ST_OFF) begin
            seq_cnt_reg <= seq_cnt_reg + 1'b1;
        end
    end

    // Gain full on wake; stepped down to zero over the power-down budget
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            gain_reg <= seq_pkg::GAIN_ZERO;
        end else if (state_next == seq_pkg::ST_ACTIVE && state_reg == seq_pkg::ST_SLEEP) begin
            gain_reg <= seq_pkg::GAIN_FULL;
        end else if (state_reg == seq_pkg::ST_RAMP && ramp_step
                     && gain_reg != seq_pkg::GAIN_ZERO) begin
            gain_reg <= gain_reg - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Format taken once as init ends; later strap moves are ignored
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            fmt_reg <= 1'b0;
        end else if (state_reg == seq_pkg::ST_INIT && init_end) begin
            fmt_reg <= fmt_s;
        end
    end

    // Config straps are only read as the device leaves sleep
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            cfg_reg <= seq_pkg::CFG_RESET;
        end else if (state_reg == seq_pkg::ST_SLEEP && state_next == seq_pkg::ST_ACTIVE) begin
            cfg_reg <= cfg_s;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt latch and registered outputs
    // ------------------------------------------------------------------
    // Sticky until the supplies cycle; nothing else clears it
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            gpo_reg <= 1'b0;
        end else if (clock_lost) begin
            gpo_reg <= 1'b1;
        end
    end

    // Outputs follow the next state so they line up with state_reg
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            sleep_reg <= 1'b0;
            chan_reg <= seq_pkg::CHAN_NONE;
            tx_reg <= 1'b0;
            low_power_reg <= 1'b0;
            init_done_reg <= 1'b0;
        end else begin
            sleep_reg <= state_next == seq_pkg::ST_SLEEP;
            chan_reg <= (state_next == seq_pkg::ST_ACTIVE) ?
                        seq_pkg::CHAN_ALL : seq_pkg::CHAN_NONE;
            tx_reg <= state_next == seq_pkg::ST_ACTIVE;
            low_power_reg <= state_next == seq_pkg::ST_OFF;
            init_done_reg <= state_next != seq_pkg::ST_INIT;
        end
    end

    assign GENERAL_PURPOSE_OUTPUT_PIN = gpo_reg;
    assign SLEEP_STATE = sleep_reg;
    assign CHANNEL_POWER = chan_reg;
    assign TRANSMIT_ENABLE = tx_reg;
    assign FORMAT_SEL = fmt_reg;
    assign CONFIG_SEL = cfg_reg;
    assign RECORD_GAIN = gain_reg;
    assign LOW_POWER = low_power_reg;
    assign INIT_DONE = init_done_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    sequence s_awake;
        state_reg == seq_pkg::ST_ACTIVE && CHANNEL_POWER == seq_pkg::CHAN_ALL && TRANSMIT_ENABLE;
    endsequence

    sequence s_shut;
        state_reg == seq_pkg::ST_SHUTDOWN && CHANNEL_POWER == seq_pkg::CHAN_NONE
        && !TRANSMIT_ENABLE;
    endsequence

    format_frozen_a: assert property (INIT_DONE && !(state_reg == seq_pkg::ST_INIT) |=> $stable(FORMAT_SEL))
        else $error("format changed after capture");

    init_length_a: assert property ($rose(INIT_DONE) |-> $past(init_end))
        else $error("init ended early");

    sleep_hold_a: assert property (state_reg == seq_pkg::ST_SLEEP
        && !clocks_present && !pfail_s |=> state_reg == seq_pkg::ST_SLEEP && SLEEP_STATE)
        else $error("left sleep without clocks");

    wake_up_a: assert property (state_reg == seq_pkg::ST_SLEEP && clocks_present
        && !pfail_s |=> s_awake)
        else $error("no wake on clocks");

    stop_shutdown_a: assert property (state_reg == seq_pkg::ST_ACTIVE
        && !clocks_present && !pfail_s |=> s_shut ##1 !TRANSMIT_ENABLE)
        else $error("no shutdown on clock stop");

    power_ramp_a: assert property (pfail_s && state_reg == seq_pkg::ST_ACTIVE
        |=> state_reg == seq_pkg::ST_RAMP && CHANNEL_POWER == seq_pkg::CHAN_NONE)
        else $error("no ramp on power down");

    gain_fall_a: assert property (state_reg == seq_pkg::ST_RAMP && ramp_step
        && gain_reg != seq_pkg::GAIN_ZERO |=> RECORD_GAIN == $past(RECORD_GAIN) - 1'b1)
        else $error("gain step wrong");

    gpo_sticky_a: assert property (GENERAL_PURPOSE_OUTPUT_PIN |=> GENERAL_PURPOSE_OUTPUT_PIN)
        else $error("interrupt cleared without reset");

    gpo_set_a: assert property (clock_lost |=> GENERAL_PURPOSE_OUTPUT_PIN)
        else $error("interrupt not raised");

    bclk_timeout_a: assert property (!bclk_evt
        && bclk_idle_reg == seq_pkg::CNT_W'(seq_pkg::BCLK_TIMEOUT_CYCLES - 1)
        |=> !bclk_alive_reg && !clocks_present)
        else $error("bit clock timeout missed");
endmodule

// [bench/host_clock_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Host side: serial bit clock and frame sync
// ----------------------------------------
module host_clock_model #(
    parameter int FRAME_BITS = 64
) (
    input wire logic run, // Clocks on while high
    input wire logic frame_en, // Frame sync on; low models a clock error
    output logic bclk, // Serial bit clock, 6 ns period
    output logic fsync // Frame sync, launched on the falling edge
);
    int cnt;
    // Clock stands still between bursts; odd start offset keeps phase unrelated
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        cnt = 0;
        #1.3;
        forever begin
            wait (run);
            #3.0 bclk = 1'b1;
            #3.0 bclk = 1'b0;
            cnt = (cnt + 1) % FRAME_BITS;
            fsync = frame_en && (cnt < FRAME_BITS / 2);
            if (!run) begin
                fsync = 1'b0;
            end
        end
    end
endmodule

// [bench/strap_pin_wake_sequencer_tb_top.sv]
`timescale 1ns/1ps
module strap_pin_wake_sequencer_tb_top;
    localparam int INIT_P = 100;
    localparam int SHUT_P = 200;
    localparam int RAMP_P = 2560;
    localparam int FRAME_P = 300;
    logic clk_sys, resetn, run, frame_en, fmt, sdown, bclk, fsync;
    logic [5:0] cfg;
    logic general_purpose_output_pin, sleep, te, fsel, lowp, idone;
    logic [1:0] chan;
    logic [5:0] csel;
    logic [7:0] gain;
    int errors = 0;
    int samples_checked = 0;
    int n;
    // ----------------------------------------
    // Clock, host model and device
    // ----------------------------------------
    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;
    host_clock_model HOST (.run(run), .frame_en(frame_en), .bclk(bclk), .fsync(fsync));
    strap_pin_wake_sequencer #(.INIT_CYCLES(INIT_P), .SHUTDOWN_CYCLES(SHUT_P),
        .RAMP_CYCLES(RAMP_P), .FRAME_TIMEOUT_CYCLES(FRAME_P)) DUT (
        .CLK_SYS(clk_sys), .RESETN(resetn), .BCLK(bclk), .FSYNC(fsync),
        .INTERFACE_FORMAT_STRAP(fmt), .CONFIG_STRAP(cfg), .SUPPLY_DOWN(sdown),
        .GENERAL_PURPOSE_OUTPUT_PIN(general_purpose_output_pin), .SLEEP_STATE(sleep), .CHANNEL_POWER(chan),
        .TRANSMIT_ENABLE(te), .FORMAT_SEL(fsel), .CONFIG_SEL(csel), .RECORD_GAIN(gain),
        .LOW_POWER(lowp), .INIT_DONE(idone));
    // ----------------------------------------
    // Compare, wait and closing tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic sig(input int sel);
        case (sel)
            0: sig = idone;
            1: sig = te;
            2: sig = sleep;
            default: sig = lowp;
        endcase
    endfunction
    // Bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_sig(input int sel, input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (sig(sel) !== lvl && cnt < lim) begin
            @(negedge clk_sys);
            cnt++;
        end
        if (sig(sel) !== lvl) begin
            check(8'(sig(sel)), 8'(lvl));
            report_and_stop();
        end
    endtask
    // Supply cycle: straps already set, clocks stopped
    task automatic power_up();
        resetn = 1'b0;
        repeat (3) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        check(8'(idone), 8'h00);
        check(8'(general_purpose_output_pin), 8'h00);
        wait_sig(0, 1'b1, INIT_P + 20, n);
        check(8'(n >= INIT_P - 3), 8'h01);
        check(8'(sleep), 8'h01);
    endtask
    task automatic wake(input logic [5:0] straps);
        run = 1'b1;
        wait_sig(1, 1'b1, 60, n);
        check(8'(chan), 8'h03);
        check(8'(sleep), 8'h00);
        check(8'(csel), 8'(straps));
        check(gain, 8'hFF);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        run = 1'b0;
        frame_en = 1'b1;
        fmt = 1'b1;
        cfg = 6'h2A;
        sdown = 1'b0;
        power_up();
        check(8'(fsel), 8'h01);
        fmt = 1'b0;
        repeat (20) @(negedge clk_sys);
        check(8'(fsel), 8'h01);
        check(8'(chan), 8'h00);
        $display("test init done");
        wake(6'h2A);
        run = 1'b0;
        wait_sig(1, 1'b0, 400, n);
        check(8'(n >= 240), 8'h01);
        check(8'(chan), 8'h00);
        check(8'(general_purpose_output_pin), 8'h01);
        wait_sig(2, 1'b1, SHUT_P + 20, n);
        check(8'(n >= SHUT_P - 3), 8'h01);
        cfg = 6'h15;
        $display("test wake and stop done");
        power_up();
        check(8'(fsel), 8'h00);
        wake(6'h15);
        frame_en = 1'b0;
        wait_sig(1, 1'b0, FRAME_P + 60, n);
        check(8'(general_purpose_output_pin), 8'h01);
        run = 1'b0;
        frame_en = 1'b1;
        wait_sig(2, 1'b1, SHUT_P + 20, n);
        $display("test clock error done");
        wake(6'h15);
        sdown = 1'b1;
        wait_sig(1, 1'b0, 10, n);
        check(8'(chan), 8'h00);
        repeat (30) @(negedge clk_sys);
        check(8'(gain < 8'hFF && gain > 8'hF0), 8'h01);
        wait_sig(3, 1'b1, RAMP_P + 100, n);
        check(8'(n >= RAMP_P - 60), 8'h01);
        check(gain, 8'h00);
        repeat (50) @(negedge clk_sys);
        check(8'(te), 8'h00);
        run = 1'b0;
        sdown = 1'b0;
        repeat (100) @(negedge clk_sys);
        power_up();
        check(8'(lowp), 8'h00);
        $display("test power-down done");
        report_and_stop();
    end
    // Whole-run limit
    initial begin
        #700000;
        errors++;
        report_and_stop();
    end
endmodule
